// file: canrx_pkg.sv
// constants, types and helpers shared by the receive process channel files
`default_nettype none

package canrx_pkg;

   // ****************************************
   // channel geometry
   // ****************************************
   localparam int NUM_CH = 4;
   localparam int MAP_ENTRIES = 4;
   localparam int MAX_BYTES = 8;
   localparam int DATA_W = MAX_BYTES * 8;
   localparam int CH_W = 2;
   localparam int ENT_W = 2;
   localparam int ADDR_W = CH_W + ENT_W;
   localparam int POS_W = 10;
   localparam int FRAME_W = 1 + 4 + 11 + DATA_W;

   // ****************************************
   // object dictionary layout
   // ****************************************
   localparam logic [15:0] COMM_INDEX_BASE = 16'h1400;
   localparam logic [15:0] MAP_INDEX_BASE = 16'h1600;
   localparam logic [7:0] SUB_FIRST = 8'h00;
   localparam logic [7:0] SUB_COB = 8'h01;
   localparam logic [7:0] SUB_TYPE = 8'h02;
   localparam logic [7:0] SUB_LAST_ENTRY = 8'h04;
   localparam logic [7:0] COMM_LAST_SUB = 8'h02;

   // ****************************************
   // identifier word fields
   // ****************************************
   localparam int COB_DISABLE_BIT = 31;
   localparam int COB_ID_MSB = 10;
   localparam logic [10:0] COB_BASE_FIRST = 11'h200;
   localparam logic [10:0] COB_BASE_STEP = 11'h100;

   // ****************************************
   // transmission types and reset values
   // ****************************************
   localparam logic [7:0] TYPE_SYNC_MAX = 8'hf0;
   localparam logic [7:0] TYPE_ASYNC_MIN = 8'hfe;
   localparam logic [7:0] TYPE_RESET = 8'hfe;
   localparam logic [7:0] MAP_COUNT_RESET = 8'h00;
   localparam logic [7:0] MAP_COUNT_MAX = 8'h04;
   localparam logic [31:0] DEF_MAP_FIRST = 32'h22ac0010;
   localparam logic [31:0] DEF_MAP_SECOND = 32'h22ad0010;
   localparam logic [10:0] SYNC_ID_RESET = 11'h080;

   // ****************************************
   // mapping entry fields
   // ****************************************
   localparam int MAP_INDEX_LSB = 16;
   localparam int MAP_SUB_LSB = 8;
   localparam int MAP_SIZE_LSB = 0;

   typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_EMIT} eng_state_type;

   // receive channels accept only sync types and the two asynchronous ones
   function automatic logic type_valid(input logic [7:0] t);
      type_valid = (t <= TYPE_SYNC_MAX) || (t >= TYPE_ASYNC_MIN);
   endfunction : type_valid

   function automatic logic [DATA_W-1:0] size_mask(input logic [7:0] size);
      if (size >= 8'(DATA_W)) begin
         size_mask = '1;
      end else begin
         size_mask = (64'h1 << size) - 64'h1;
      end
   endfunction : size_mask

   function automatic logic [31:0] default_cob(input int ch, input logic [6:0] node);
      default_cob = {21'h0, COB_BASE_FIRST + 11'(ch) * COB_BASE_STEP + {4'h0, node}};
   endfunction : default_cob

endpackage : canrx_pkg

`default_nettype wire

// file: canrx_fifo.sv
// small frame fifo with valid and ready on both sides
`default_nettype none

module canrx_fifo #(
   parameter int WIDTH = 80,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0] cnt_ff, nxt_cnt;
   logic full_ff, nxt_full, room_ff, nxt_room;
   logic push, pop;

   always_comb begin
      push = in_valid && room_ff;
      pop = out_ready && (cnt_ff != '0);
      nxt_wr = push ? ((wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
      nxt_rd = pop ? ((rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
      nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
      nxt_full = (nxt_cnt == (PW+1)'(DEPTH));
      nxt_room = !nxt_full;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         full_ff <= 1'b0;
         room_ff <= 1'b0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         full_ff <= nxt_full;
         room_ff <= nxt_room;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   assign in_ready = room_ff;
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];

endmodule : canrx_fifo

`default_nettype wire

// file: canrx_map_mem.sv
// mapping table of all channels, one write port and two registered read ports
`default_nettype none

module canrx_map_mem
   import canrx_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // write port
   input wire logic wr_en,
   input wire logic [canrx_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [31:0] wr_data,
   // read port for the unpack engine
   input wire logic [canrx_pkg::ADDR_W-1:0] rd_addr_a,
   output logic [31:0] rd_data_a,
   // read port for dictionary reads
   input wire logic [canrx_pkg::ADDR_W-1:0] rd_addr_b,
   output logic [31:0] rd_data_b
);

   localparam int WORDS = NUM_CH * MAP_ENTRIES;

   logic [31:0] mem_ff [WORDS];

   // reset loads the default two-object map into every channel
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_ff[i] <= (i % MAP_ENTRIES == 0) ? DEF_MAP_FIRST :
                         (i % MAP_ENTRIES == 1) ? DEF_MAP_SECOND : 32'h0;
         end
         rd_data_a <= 32'h0;
         rd_data_b <= 32'h0;
      end else begin
         if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
         end
         rd_data_a <= mem_ff[rd_addr_a];
         rd_data_b <= mem_ff[rd_addr_b];
      end
   end

endmodule : canrx_map_mem

`default_nettype wire

// file: canopen_receive_pdo_handler.sv
// receive process channels: filter, sync hold and unpack into mapped objects
`default_nettype none

module canopen_receive_pdo_handler
   import canrx_pkg::*;
#(
   parameter logic [10:0] SYNC_ID = canrx_pkg::SYNC_ID_RESET,
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // node state
   input wire logic [6:0] node_id,
   input wire logic nmt_operational,
   // received frames
   input wire logic frame_valid,
   input wire logic [10:0] frame_id,
   input wire logic frame_rtr,
   input wire logic [3:0] frame_dlc,
   input wire logic [canrx_pkg::DATA_W-1:0] frame_data,
   output logic frame_ready,
   // object dictionary access
   input wire logic od_req,
   input wire logic od_write,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_subindex,
   input wire logic [31:0] od_wdata,
   output logic od_ack,
   output logic od_err,
   output logic [31:0] od_rdata,
   // mapped object writes
   output logic obj_wr,
   output logic [15:0] obj_index,
   output logic [7:0] obj_subindex,
   output logic [7:0] obj_size,
   output logic [canrx_pkg::DATA_W-1:0] obj_value,
   // status
   output logic [canrx_pkg::NUM_CH-1:0] chan_pending
);

   import canrx_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [31:0] cob_ff [NUM_CH];
   logic [31:0] nxt_cob [NUM_CH];
   logic [7:0] type_ff [NUM_CH];
   logic [7:0] nxt_type [NUM_CH];
   logic [7:0] cnt_ff [NUM_CH];
   logic [7:0] nxt_cnt [NUM_CH];
   logic p1_ff, nxt_p1, p1_err_ff, nxt_p1_err, p1_mem_ff, nxt_p1_mem;
   logic [31:0] p1_rdata_ff, nxt_p1_rdata;
   logic od_ack_ff, nxt_od_ack, od_err_ff, nxt_od_err;
   logic [31:0] od_rdata_ff, nxt_od_rdata;
   logic mem_we;
   logic [ADDR_W-1:0] mem_waddr, mem_raddr_b;
   logic [31:0] mem_rdata_a, mem_rdata_b;

   logic [NUM_CH-1:0] pend_ff, nxt_pend, rdy_ff, nxt_rdy;
   logic [DATA_W-1:0] pend_data_ff [NUM_CH];
   logic [DATA_W-1:0] nxt_pend_data [NUM_CH];
   logic [DATA_W-1:0] rdy_data_ff [NUM_CH];
   logic [DATA_W-1:0] nxt_rdy_data [NUM_CH];
   logic [3:0] pend_dlc_ff [NUM_CH];
   logic [3:0] nxt_pend_dlc [NUM_CH];
   logic [3:0] rdy_dlc_ff [NUM_CH];
   logic [3:0] nxt_rdy_dlc [NUM_CH];
   eng_state_type st_ff, nxt_st;
   logic [CH_W-1:0] ch_ff, nxt_ch;
   logic [ENT_W-1:0] ent_ff, nxt_ent;
   logic [POS_W-1:0] pos_ff, nxt_pos;
   logic [DATA_W-1:0] work_ff, nxt_work;
   logic [3:0] wdlc_ff, nxt_wdlc;
   logic obj_wr_ff, nxt_obj_wr;
   logic [15:0] obj_index_ff, nxt_obj_index;
   logic [7:0] obj_sub_ff, nxt_obj_sub, obj_size_ff, nxt_obj_size;
   logic [DATA_W-1:0] obj_value_ff, nxt_obj_value;
   logic [NUM_CH-1:0] pending_ff, nxt_pending;

   logic f_valid, f_pop, f_rtr, fifo_ready_ff;
   logic [FRAME_W-1:0] f_word;
   logic [10:0] f_id;
   logic [3:0] f_dlc;
   logic [DATA_W-1:0] f_data;

   // ****************************************
   // frame buffer
   // ****************************************
   canrx_fifo #(
      .WIDTH(FRAME_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(frame_valid),
      .in_data({frame_rtr, frame_dlc, frame_id, frame_data}),
      .in_ready(fifo_ready_ff),
      .out_valid(f_valid),
      .out_data(f_word),
      .out_ready(f_pop)
   );

   assign {f_rtr, f_dlc, f_id, f_data} = f_word;
   // frames are drained only while the unpack engine is idle
   assign f_pop = f_valid && (st_ff == ENG_IDLE);

   canrx_map_mem u_map (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(od_wdata),
      .rd_addr_a({ch_ff, ent_ff}),
      .rd_data_a(mem_rdata_a),
      .rd_addr_b(mem_raddr_b),
      .rd_data_b(mem_rdata_b)
   );

   // ****************************************
   // object dictionary access
   // ****************************************
   always_comb begin
      logic [CH_W-1:0] c;
      logic is_comm, is_map, ok;
      logic [7:0] sub_m1;
      c = od_index[CH_W-1:0];
      is_comm = (od_index[15:CH_W] == COMM_INDEX_BASE[15:CH_W]);
      is_map = (od_index[15:CH_W] == MAP_INDEX_BASE[15:CH_W]);
      sub_m1 = od_subindex - 8'h01;
      nxt_cob = cob_ff;
      nxt_type = type_ff;
      nxt_cnt = cnt_ff;
      ok = 1'b0;
      nxt_p1_rdata = 32'h0;
      nxt_p1_mem = 1'b0;
      mem_we = 1'b0;
      mem_waddr = {c, sub_m1[ENT_W-1:0]};
      mem_raddr_b = {c, sub_m1[ENT_W-1:0]};
      if (od_req && is_comm) begin
         unique case (od_subindex)
            SUB_FIRST: begin
               ok = !od_write;
               nxt_p1_rdata = {24'h0, COMM_LAST_SUB};
            end
            SUB_COB: begin
               ok = 1'b1;
               nxt_p1_rdata = cob_ff[c];
               if (od_write) begin
                  nxt_cob[c] = od_wdata;
               end
            end
            SUB_TYPE: begin
               ok = !od_write || type_valid(od_wdata[7:0]);
               nxt_p1_rdata = {24'h0, type_ff[c]};
               if (od_write && ok) begin
                  nxt_type[c] = od_wdata[7:0];
               end
            end
            default: ok = 1'b0;
         endcase
      end else if (od_req && is_map) begin
         if (od_subindex == SUB_FIRST) begin
            ok = !od_write || (od_wdata <= {24'h0, MAP_COUNT_MAX});
            nxt_p1_rdata = {24'h0, cnt_ff[c]};
            if (od_write && ok) begin
               nxt_cnt[c] = od_wdata[7:0];
            end
         end else if (od_subindex <= SUB_LAST_ENTRY) begin
            // entries may change only while the channel is switched off
            ok = !od_write || (cnt_ff[c] == 8'h00);
            nxt_p1_mem = !od_write;
            mem_we = od_write && ok;
         end
      end
      nxt_p1 = od_req;
      nxt_p1_err = od_req && !ok;
      nxt_od_ack = p1_ff;
      nxt_od_err = p1_err_ff;
      nxt_od_rdata = p1_mem_ff ? mem_rdata_b : p1_rdata_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cob_ff[i] <= default_cob(i, node_id);
            type_ff[i] <= TYPE_RESET;
            cnt_ff[i] <= MAP_COUNT_RESET;
         end
         p1_ff <= 1'b0;
         p1_err_ff <= 1'b0;
         p1_mem_ff <= 1'b0;
         p1_rdata_ff <= 32'h0;
         od_ack_ff <= 1'b0;
         od_err_ff <= 1'b0;
         od_rdata_ff <= 32'h0;
      end else begin
         cob_ff <= nxt_cob;
         type_ff <= nxt_type;
         cnt_ff <= nxt_cnt;
         p1_ff <= nxt_p1;
         p1_err_ff <= nxt_p1_err;
         p1_mem_ff <= nxt_p1_mem;
         p1_rdata_ff <= nxt_p1_rdata;
         od_ack_ff <= nxt_od_ack;
         od_err_ff <= nxt_od_err;
         od_rdata_ff <= nxt_od_rdata;
      end
   end

   // ****************************************
   // frame filter, sync hold and unpack engine
   // ****************************************
   always_comb begin
      logic hit;
      logic [7:0] size;
      logic [POS_W-1:0] endpos;
      logic [CH_W-1:0] pick;
      hit = 1'b0;
      nxt_pend = pend_ff;
      nxt_pend_data = pend_data_ff;
      nxt_pend_dlc = pend_dlc_ff;
      nxt_rdy = rdy_ff;
      nxt_rdy_data = rdy_data_ff;
      nxt_rdy_dlc = rdy_dlc_ff;
      nxt_st = st_ff;
      nxt_ch = ch_ff;
      nxt_ent = ent_ff;
      nxt_pos = pos_ff;
      nxt_work = work_ff;
      nxt_wdlc = wdlc_ff;
      nxt_obj_wr = 1'b0;
      nxt_obj_index = obj_index_ff;
      nxt_obj_sub = obj_sub_ff;
      nxt_obj_size = obj_size_ff;
      nxt_obj_value = obj_value_ff;
      size = mem_rdata_a[MAP_SIZE_LSB +: 8];
      endpos = pos_ff + POS_W'(size);
      pick = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (rdy_ff[i]) begin
            pick = CH_W'(i);
         end
      end
      unique case (st_ff)
         ENG_IDLE: begin
            if (rdy_ff != '0) begin
               nxt_ch = pick;
               nxt_work = rdy_data_ff[pick];
               nxt_wdlc = rdy_dlc_ff[pick];
               nxt_rdy[pick] = 1'b0;
               nxt_ent = '0;
               nxt_pos = '0;
               nxt_st = ENG_FETCH;
            end
         end
         ENG_FETCH: nxt_st = ENG_EMIT;
         ENG_EMIT: begin
            // objects beyond the frame's bytes or eight bytes are skipped
            if (size != 8'h00 && endpos <= POS_W'({wdlc_ff, 3'b000})
                && endpos <= POS_W'(DATA_W)) begin
               nxt_obj_wr = 1'b1;
               nxt_obj_index = mem_rdata_a[MAP_INDEX_LSB +: 16];
               nxt_obj_sub = mem_rdata_a[MAP_SUB_LSB +: 8];
               nxt_obj_size = size;
               nxt_obj_value = (work_ff >> pos_ff) & size_mask(size);
            end
            nxt_pos = endpos;
            if ({6'h0, ent_ff} + 8'h01 >= cnt_ff[ch_ff]) begin
               nxt_st = ENG_IDLE;
            end else begin
               nxt_ent = ent_ff + 1'b1;
               nxt_st = ENG_FETCH;
            end
         end
      endcase
      if (f_pop && f_id == SYNC_ID) begin
         // sync releases held data whatever its length
         for (int i = 0; i < NUM_CH; i++) begin
            if (pend_ff[i]) begin
               nxt_rdy[i] = 1'b1;
               nxt_rdy_data[i] = pend_data_ff[i];
               nxt_rdy_dlc[i] = pend_dlc_ff[i];
               nxt_pend[i] = 1'b0;
            end
         end
      end else if (f_pop && !f_rtr && nmt_operational) begin
         for (int i = 0; i < NUM_CH; i++) begin
            hit = !cob_ff[i][COB_DISABLE_BIT]
                  && (f_id == cob_ff[i][COB_ID_MSB:0])
                  && (cnt_ff[i] != 8'h00) && (cnt_ff[i] <= MAP_COUNT_MAX)
                  && type_valid(type_ff[i]);
            if (hit && type_ff[i] <= TYPE_SYNC_MAX) begin
               nxt_pend[i] = 1'b1;
               nxt_pend_data[i] = f_data;
               nxt_pend_dlc[i] = f_dlc;
            end else if (hit) begin
               nxt_rdy[i] = 1'b1;
               nxt_rdy_data[i] = f_data;
               nxt_rdy_dlc[i] = f_dlc;
            end
         end
      end
      nxt_pending = nxt_pend | nxt_rdy;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_ff <= '0;
         rdy_ff <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            pend_data_ff[i] <= '0;
            rdy_data_ff[i] <= '0;
            pend_dlc_ff[i] <= 4'h0;
            rdy_dlc_ff[i] <= 4'h0;
         end
         st_ff <= ENG_IDLE;
         ch_ff <= '0;
         ent_ff <= '0;
         pos_ff <= '0;
         work_ff <= '0;
         wdlc_ff <= 4'h0;
         obj_wr_ff <= 1'b0;
         obj_index_ff <= 16'h0;
         obj_sub_ff <= 8'h0;
         obj_size_ff <= 8'h0;
         obj_value_ff <= '0;
         pending_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
         rdy_ff <= nxt_rdy;
         pend_data_ff <= nxt_pend_data;
         rdy_data_ff <= nxt_rdy_data;
         pend_dlc_ff <= nxt_pend_dlc;
         rdy_dlc_ff <= nxt_rdy_dlc;
         st_ff <= nxt_st;
         ch_ff <= nxt_ch;
         ent_ff <= nxt_ent;
         pos_ff <= nxt_pos;
         work_ff <= nxt_work;
         wdlc_ff <= nxt_wdlc;
         obj_wr_ff <= nxt_obj_wr;
         obj_index_ff <= nxt_obj_index;
         obj_sub_ff <= nxt_obj_sub;
         obj_size_ff <= nxt_obj_size;
         obj_value_ff <= nxt_obj_value;
         pending_ff <= nxt_pending;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign frame_ready = fifo_ready_ff;
   assign od_ack = od_ack_ff;
   assign od_err = od_err_ff;
   assign od_rdata = od_rdata_ff;
   assign obj_wr = obj_wr_ff;
   assign obj_index = obj_index_ff;
   assign obj_subindex = obj_sub_ff;
   assign obj_size = obj_size_ff;
   assign obj_value = obj_value_ff;
   assign chan_pending = pending_ff;

endmodule : canopen_receive_pdo_handler

`default_nettype wire

// file: canrx_node_model.sv
// frame source standing for the other nodes on the bus
`default_nettype none

module canrx_node_model
   import canrx_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // frame handshake
   output logic frame_valid,
   output logic [10:0] frame_id,
   output logic frame_rtr,
   output logic [3:0] frame_dlc,
   output logic [canrx_pkg::DATA_W-1:0] frame_data,
   input wire logic frame_ready
);
   timeunit 1ns;
   timeprecision 100ps;

   int lost = 0;

   initial begin
      frame_valid = 1'b0;
      frame_id = 11'h7ff;
      frame_rtr = 1'b0;
      frame_dlc = 4'h0;
      frame_data = '0;
   end

   // frame held until ready is seen or 100 cycles pass, then data line scrambled
   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
      int n;
      @(posedge ref_clk);
      #1;
      frame_valid = 1'b1;
      frame_id = id;
      frame_dlc = dlc;
      frame_data = d;
      for (n = 0; n < 100 && frame_ready !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n == 100) lost++;
      @(posedge ref_clk);
      #1;
      frame_valid = 1'b0;
      frame_id = ~id;
      frame_data = ~d;
   endtask : send

endmodule : canrx_node_model

`default_nettype wire

// file: canrx_chk.sv
// assertions on the receive channel handler ports
`default_nettype none

module canrx_chk
   import canrx_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // dictionary
   input wire logic od_req,
   input wire logic od_write,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_subindex,
   input wire logic [31:0] od_wdata,
   input wire logic od_ack,
   input wire logic od_err,
   input wire logic [31:0] od_rdata,
   // objects
   input wire logic obj_wr,
   input wire logic [7:0] obj_size
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic comm_hit;
   logic map_hit;
   assign comm_hit = od_req && od_index[15:2] == 14'h0500;
   assign map_hit = od_req && od_index[15:2] == 14'h0580;

   sequence s_answer;
      ##2 od_ack;
   endsequence
   sequence s_refused;
      ##2 (od_ack && od_err);
   endsequence

   a_answer_delay: assert property (od_req |-> s_answer)
      else $error("dictionary answer not after two cycles");
   a_answer_cause: assert property (od_ack |-> $past(od_req, 2))
      else $error("answer without request");
   a_err_with_ack: assert property (od_err |-> od_ack)
      else $error("error outside answer");
   a_last_sub_value: assert property (comm_hit && !od_write && od_subindex == 8'h00
      |-> ##2 (od_rdata == 32'h2 && !od_err))
      else $error("last sub-index not 2");
   a_last_sub_ro: assert property (comm_hit && od_write && od_subindex == 8'h00
      |-> s_refused)
      else $error("read-only entry written");
   a_type_refused: assert property (comm_hit && od_write && od_subindex == 8'h02
      && od_wdata >= 32'hf1 && od_wdata <= 32'hfd |-> s_refused)
      else $error("reserved type accepted");
   a_count_refused: assert property (map_hit && od_write && od_subindex == 8'h00
      && od_wdata > 32'h4 |-> s_refused)
      else $error("map count above four accepted");
   a_obj_size_legal: assert property (obj_wr |-> obj_size inside {[8'h01:8'h40]})
      else $error("object size out of range");
   a_obj_hold: assert property (!obj_wr |-> $stable(obj_size))
      else $error("object size moved without write");

endmodule : canrx_chk

bind canopen_receive_pdo_handler canrx_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .od_req(od_req), .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
   .od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
   .obj_wr(obj_wr), .obj_size(obj_size));

`default_nettype wire

// file: test_canopen_receive_pdo_handler.sv
// self-checking bench for the receive channel handler
`default_nettype none

module test_canopen_receive_pdo_handler import canrx_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk, rst_n, nmt_operational, frame_valid, frame_rtr, frame_ready;
   logic od_req, od_write, od_ack, od_err, obj_wr;
   logic [6:0] node_id;
   logic [10:0] frame_id;
   logic [3:0] frame_dlc, chan_pending;
   logic [63:0] frame_data, obj_value, d;
   logic [15:0] od_index, obj_index;
   logic [7:0] od_subindex, obj_subindex, obj_size;
   logic [31:0] od_wdata, od_rdata;
   logic [31:0] bad[4] = '{32'hf1, 32'hfb, 32'hfc, 32'hfd};
   logic [33:0] od_q[$];
   logic [95:0] obj_q[$];
   logic [33:0] e;
   logic [95:0] f;
   int failures = 0;
   int total_checks = 0;

   canopen_receive_pdo_handler #(.FIFO_DEPTH(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .node_id(node_id), .nmt_operational(nmt_operational), .frame_valid(frame_valid),
      .frame_id(frame_id), .frame_rtr(frame_rtr), .frame_dlc(frame_dlc),
      .frame_data(frame_data), .frame_ready(frame_ready), .od_req(od_req),
      .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
      .od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
      .obj_wr(obj_wr), .obj_index(obj_index), .obj_subindex(obj_subindex),
      .obj_size(obj_size), .obj_value(obj_value), .chan_pending(chan_pending));

   canrx_node_model node (.ref_clk(ref_clk), .frame_valid(frame_valid), .frame_id(frame_id),
      .frame_rtr(frame_rtr), .frame_dlc(frame_dlc), .frame_data(frame_data),
      .frame_ready(frame_ready));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] cob(input int ch);
      cob = 32'h200 + 32'(ch) * 32'h100 + 32'(node_id);
   endfunction : cob

   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize;
      failures += node.lost;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic err, input logic [31:0] rd);
      od_q.push_back({!wr && !err, err, rd});
      @(posedge ref_clk);
      #1;
      od_req = 1'b1;
      od_write = wr;
      od_index = idx;
      od_subindex = sub;
      od_wdata = wd;
      @(posedge ref_clk);
      #1;
      od_req = 1'b0;
   endtask : od

   task automatic drain(input string name);
      int n;
      for (n = 0; n < 300 && (od_q.size() + obj_q.size()) > 0; n++) @(posedge ref_clk);
      if (n == 300) begin
         failures++;
         summarize();
      end
      repeat (12) @(posedge ref_clk);
      #1;
      $display("test %s done", name);
   endtask : drain

   // ****************************************
   // result watcher
   // ****************************************
   always @(negedge ref_clk) begin
      if (od_ack === 1'b1) begin
         e = od_q.size() > 0 ? od_q.pop_front() : '1;
         check(96'({od_err, e[33] ? od_rdata : e[31:0]}), 96'(e[32:0]));
      end
      if (obj_wr === 1'b1) begin
         f = obj_q.size() > 0 ? obj_q.pop_front() : '1;
         check({obj_index, obj_subindex, obj_size, obj_value & ((64'h1 << obj_size) - 64'h1)},
            f);
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      void'($urandom(32'h73ccb420));
      {rst_n, nmt_operational, od_req, od_write, od_index, od_subindex, od_wdata} = '0;
      node_id = 7'($urandom());
      repeat (6) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      for (int ch = 0; ch < 4; ch++) begin
         od(0, 16'h1400 + 16'(ch), 8'h00, 0, 0, 32'h2);
         od(0, 16'h1400 + 16'(ch), 8'h01, 0, 0, cob(ch));
         od(0, 16'h1400 + 16'(ch), 8'h02, 0, 0, 32'hfe);
         od(0, 16'h1600 + 16'(ch), 8'h00, 0, 0, 32'h0);
         od(0, 16'h1600 + 16'(ch), 8'h01, 0, 0, 32'h22ac0010);
         od(0, 16'h1600 + 16'(ch), 8'h02, 0, 0, 32'h22ad0010);
      end
      drain("reset values");
      check(96'(frame_ready), 96'h1);
      od(1, 16'h1400, 8'h00, 32'h5, 1, 0);
      foreach (bad[i]) od(1, 16'h1401, 8'h02, bad[i], 1, 0);
      od(0, 16'h1401, 8'h02, 0, 0, 32'hfe);
      od(1, 16'h1600, 8'h00, 32'h5, 1, 0);
      od(0, 16'h1700, 8'h00, 0, 1, 0);
      od(1, 16'h1600, 8'h00, 32'h2, 0, 0);
      od(1, 16'h1600, 8'h01, 32'h12340008, 1, 0);
      od(0, 16'h1600, 8'h01, 0, 0, 32'h22ac0010);
      drain("refusals");
      nmt_operational = 1'b1;
      d = {$urandom(), $urandom()};
      obj_q.push_back({16'h22ac, 8'h00, 8'h10, 48'h0, d[15:0]});
      obj_q.push_back({16'h22ad, 8'h00, 8'h10, 48'h0, d[31:16]});
      node.send(11'(cob(0)), 4'h4, d);
      node.send(11'(cob(0)) ^ 11'h001, 4'h4, d);
      node.frame_rtr = 1'b1;
      node.send(11'(cob(0)), 4'h4, d);
      node.frame_rtr = 1'b0;
      drain("immediate");
      od(1, 16'h1400, 8'h01, 32'h80000000 | cob(0), 0, 0);
      node.send(11'(cob(0)), 4'h8, d);
      drain("disabled");
      od(1, 16'h1400, 8'h01, cob(0), 0, 0);
      nmt_operational = 1'b0;
      node.send(11'(cob(0)), 4'h8, d);
      drain("not operational");
      nmt_operational = 1'b1;
      od(1, 16'h1402, 8'h02, 32'hff, 0, 0);
      od(1, 16'h1602, 8'h01, 32'h20640008, 0, 0);
      od(1, 16'h1602, 8'h02, 32'h20650118, 0, 0);
      od(1, 16'h1602, 8'h00, 32'h2, 0, 0);
      od(1, 16'h1401, 8'h02, 32'hf0, 0, 0);
      od(1, 16'h1601, 8'h00, 32'h1, 0, 0);
      d = {$urandom(), $urandom()};
      obj_q.push_back({16'h2064, 8'h00, 8'h08, 56'h0, d[7:0]});
      obj_q.push_back({16'h2065, 8'h01, 8'h18, 40'h0, d[31:8]});
      node.send(11'(cob(2)), 4'h4, d);
      node.send(11'(cob(1)), 4'h2, ~d);
      drain("remap");
      check(96'(chan_pending), 96'h2);
      obj_q.push_back({16'h22ac, 8'h00, 8'h10, 48'h0, ~d[15:0]});
      node.send(SYNC_ID_RESET, 4'h0, 64'h0);
      drain("sync");
      check(96'(chan_pending), 96'h0);
      summarize();
   end

endmodule : test_canopen_receive_pdo_handler

`default_nettype wire
